/* File: design/awm_pkg.sv */
// package for the alarm weekday match block: register map, layouts, carriers
package awm_pkg;
    // internal register addresses (4-bit pointer space)
    localparam logic [3:0] ADDR_A_MIN  = 4'h8;
    localparam logic [3:0] ADDR_A_HOUR = 4'h9;
    localparam logic [3:0] ADDR_A_DAY  = 4'ha;
    localparam logic [3:0] ADDR_B_MIN  = 4'hb;
    localparam logic [3:0] ADDR_B_HOUR = 4'hc;
    localparam logic [3:0] ADDR_B_DAY  = 4'hd;
    // field positions and masks
    localparam int         HOUR_D5_POS = 5;
    localparam logic [7:0] MIN_MASK    = 8'h7f;
    localparam logic [7:0] HOUR_MASK   = 8'h3f;
    localparam logic [7:0] DAY_MASK    = 8'h7f;
    // values after reset or oscillator halt (undefined bits cleared)
    localparam logic [6:0] MIN_RST     = 7'h00;
    localparam logic [5:0] HOUR_RST    = 6'h00;
    localparam logic [6:0] DAY_RST     = 7'h00;
    localparam int         NUM_CH      = 2;

    // one alarm channel's programmed setting
    typedef struct packed {
        logic [6:0] minute;
        logic [5:0] hour;
        logic [6:0] day_enables;
    } awm_alarm_t;

    // current time from the timekeeping counters
    typedef struct packed {
        logic [6:0] minute;
        logic [5:0] hour;
        logic [2:0] weekday_counter;
    } awm_time_t;

    // register write/read port
    typedef struct packed {
        logic       wr_en;
        logic [3:0] addr;
        logic [7:0] wdata;
    } awm_reg_req_t;
endpackage

/* File: design/awm_alarm_weekday_match.sv */
// alarm weekday match: two alarm channels with minute, hour and weekday compare
`timescale 1ns/100ps
// Function
// - alarm A weekday register at Ah, D7 zero
// - alarm B weekday register at Dh, same layout
// - enable bit n matches weekday counter n
// - all enables zero never fires
// - hour D5 is pm flag or tens
// - midnight 12, noon 32 compare natively
// - oscillator halt clears enables, D7 zero
// - alarm A minute at 8h, D7 zero
// - alarm hours at 9h, Ch, D7-D6 zero
module awm_alarm_weekday_match (
    input  wire logic                  core_clk_i,
    input  wire logic                  reset_i,
    input  wire awm_pkg::awm_reg_req_t reg_req_i,
    output logic [7:0]                 reg_rdata_o,
    input  wire awm_pkg::awm_time_t    cur_time_i,
    input  wire logic                  minute_tick_i,
    input  wire logic                  osc_halt_flag_i,
    output logic [1:0]                 alarm_pulse_o,
    output logic [1:0]                 alarm_match_o
);

    // ------------------------------------------------------------
    // alarm setting registers
    // ------------------------------------------------------------
    awm_pkg::awm_alarm_t alarm_ff     [awm_pkg::NUM_CH];
    awm_pkg::awm_alarm_t nxt_alarm    [awm_pkg::NUM_CH];
    logic [1:0]          pulse_ff;
    logic [1:0]          nxt_pulse;
    logic [7:0]          rdata_ff;
    logic [7:0]          nxt_rdata;
    logic [1:0]          match_w;

    // weekday decode, one-hot over the seven enable bits
    function automatic logic [6:0] day_decode(input logic [2:0] wd);
        day_decode = 7'h00;
        if (wd <= 3'h6)
            day_decode[wd] = 1'b1;
    endfunction

    // halt flag is treated as same-domain logic from the oscillator block;
    // while it is high the settings are held at their undefined-turned-zero values
    always_comb
    begin
        for (int c = 0; c < awm_pkg::NUM_CH; c++)
        begin
            nxt_alarm[c] = alarm_ff[c];
        end
        if (osc_halt_flag_i)
        begin
            for (int c = 0; c < awm_pkg::NUM_CH; c++)
            begin
                nxt_alarm[c] = '{awm_pkg::MIN_RST, awm_pkg::HOUR_RST, awm_pkg::DAY_RST};
            end
        end
        else if (reg_req_i.wr_en)
        begin
            unique case (reg_req_i.addr)
                awm_pkg::ADDR_A_MIN:  nxt_alarm[0].minute      = reg_req_i.wdata[6:0];
                awm_pkg::ADDR_A_HOUR: nxt_alarm[0].hour        = reg_req_i.wdata[5:0];
                awm_pkg::ADDR_A_DAY:  nxt_alarm[0].day_enables = reg_req_i.wdata[6:0];
                awm_pkg::ADDR_B_MIN:  nxt_alarm[1].minute      = reg_req_i.wdata[6:0];
                awm_pkg::ADDR_B_HOUR: nxt_alarm[1].hour        = reg_req_i.wdata[5:0];
                awm_pkg::ADDR_B_DAY:  nxt_alarm[1].day_enables = reg_req_i.wdata[6:0];
                default:              ;
            endcase
        end
    end

    // setting registers; reset gives the same cleared state as a halt,
    // so a channel never fires from leftover settings after power-up
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            for (int c = 0; c < awm_pkg::NUM_CH; c++)
            begin
                alarm_ff[c] <= '{awm_pkg::MIN_RST, awm_pkg::HOUR_RST, awm_pkg::DAY_RST};
            end
        end
        else
        begin
            for (int c = 0; c < awm_pkg::NUM_CH; c++)
            begin
                alarm_ff[c] <= nxt_alarm[c];
            end
        end
    end

    // ------------------------------------------------------------
    // read path, registered; unused bits read zero
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (reg_req_i.addr)
            awm_pkg::ADDR_A_MIN:  nxt_rdata = {1'b0, alarm_ff[0].minute};
            awm_pkg::ADDR_A_HOUR: nxt_rdata = {2'b00, alarm_ff[0].hour};
            awm_pkg::ADDR_A_DAY:  nxt_rdata = {1'b0, alarm_ff[0].day_enables};
            awm_pkg::ADDR_B_MIN:  nxt_rdata = {1'b0, alarm_ff[1].minute};
            awm_pkg::ADDR_B_HOUR: nxt_rdata = {2'b00, alarm_ff[1].hour};
            awm_pkg::ADDR_B_DAY:  nxt_rdata = {1'b0, alarm_ff[1].day_enables};
            default:              nxt_rdata = 8'h00; // other registers live elsewhere
        endcase
    end

    // read data register; costs one cycle of latency but keeps the data port glitch free
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rdata_ff <= 8'h00;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // compare, one channel per generate step
    // ------------------------------------------------------------
    // hour is compared as the raw six bits: D5 is the pm flag in 12-hour
    // mode and the upper tens bit in 24-hour mode, and the counter uses the
    // same coding (12 midnight, 32 noon), so no mode logic is needed here
    generate
        for (genvar c = 0; c < awm_pkg::NUM_CH; c++)
        begin : g_ch
            assign match_w[c] = |(alarm_ff[c].day_enables & day_decode(cur_time_i.weekday_counter))
                                && (alarm_ff[c].hour == cur_time_i.hour)
                                && (alarm_ff[c].minute == cur_time_i.minute);
        end
    endgenerate

    // one pulse per channel per minute update, only when settings are valid
    always_comb
    begin
        nxt_pulse = minute_tick_i && !osc_halt_flag_i ? match_w : 2'b00;
    end

    // pulse register; cleared on reset so no false pulse follows it
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            pulse_ff <= 2'b00;
        end
        else
        begin
            pulse_ff <= nxt_pulse;
        end
    end

    assign alarm_pulse_o = pulse_ff;
    assign reg_rdata_o   = rdata_ff;
    assign alarm_match_o = match_w;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    day_a_readzero_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (reg_req_i.addr == awm_pkg::ADDR_A_DAY) |=> (reg_rdata_o[7] == 1'b0))
        else $error("alarm A weekday D7 not zero");
    day_b_write_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (reg_req_i.wr_en && reg_req_i.addr == awm_pkg::ADDR_B_DAY && !osc_halt_flag_i)
        |=> (alarm_ff[1].day_enables == $past(reg_req_i.wdata[6:0])))
        else $error("alarm B weekday write lost");
    day_bit_match_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        match_w[0] |-> alarm_ff[0].day_enables[cur_time_i.weekday_counter] && cur_time_i.weekday_counter != 3'h7)
        else $error("match on disabled day");
    no_day_quiet_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (alarm_ff[1].day_enables == 7'h00) |=> !alarm_pulse_o[1])
        else $error("pulse with all days disabled");
    hour_raw_cmp_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        alarm_pulse_o[0] |-> $past(alarm_ff[0].hour) == $past(cur_time_i.hour))
        else $error("pulse with hour mismatch");
    halt_clear_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        osc_halt_flag_i |=> (alarm_ff[0].day_enables == 7'h00 && alarm_ff[1].day_enables == 7'h00))
        else $error("halt did not clear enables");
    hour_readzero_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (reg_req_i.addr == awm_pkg::ADDR_B_HOUR) |=> (reg_rdata_o[7:6] == 2'b00))
        else $error("hour D7-D6 not zero");
    min_readzero_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (reg_req_i.addr == awm_pkg::ADDR_A_MIN) |=> (reg_rdata_o[7] == 1'b0))
        else $error("minute D7 not zero");
    tick_pulse_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (minute_tick_i && !osc_halt_flag_i && match_w[0]) |=> alarm_pulse_o[0])
        else $error("missing alarm pulse");
    pulse_gate_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        alarm_pulse_o[1] |-> $past(minute_tick_i) && $past(match_w[1]))
        else $error("pulse without tick and match");

    // channel a write and quiet, channel b and halt checks
    day_a_write_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (reg_req_i.wr_en && reg_req_i.addr == awm_pkg::ADDR_A_DAY && !osc_halt_flag_i)
        |=> (alarm_ff[0].day_enables == $past(reg_req_i.wdata[6:0])))
        else $error("alarm A weekday write lost");
    day_b_readzero_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (reg_req_i.addr == awm_pkg::ADDR_B_DAY) |=> (reg_rdata_o[7] == 1'b0))
        else $error("alarm B weekday D7 not zero");
    day_b_match_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        match_w[1] |-> alarm_ff[1].day_enables[cur_time_i.weekday_counter] && cur_time_i.weekday_counter != 3'h7)
        else $error("channel B match on disabled day");
    hour_b_cmp_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        alarm_pulse_o[1] |-> $past(alarm_ff[1].hour) == $past(cur_time_i.hour))
        else $error("channel B pulse with hour mismatch");
    halt_no_pulse_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        osc_halt_flag_i |=> (alarm_pulse_o == 2'b00))
        else $error("pulse while oscillator halted");
    day_a_quiet_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (alarm_ff[0].day_enables == 7'h00) |=> !alarm_pulse_o[0])
        else $error("channel A pulse with all days disabled");

    pulse_a_c: cover property (@(posedge core_clk_i) disable iff (reset_i) alarm_pulse_o[0]);
    pulse_b_c: cover property (@(posedge core_clk_i) disable iff (reset_i) alarm_pulse_o[1]);
    both_c:    cover property (@(posedge core_clk_i) disable iff (reset_i) alarm_pulse_o == 2'b11);
    halt_c:    cover property (@(posedge core_clk_i) disable iff (reset_i) osc_halt_flag_i ##1 !osc_halt_flag_i);
    held_c:    cover property (@(posedge core_clk_i) disable iff (reset_i) alarm_match_o[0] && !minute_tick_i);

endmodule

/* File: testbench/awm_host_model.sv */
// host-side model that programs and reads the alarm registers
`timescale 1ns/100ps
module awm_host_model (
    input  wire logic            core_clk_i,
    input  wire logic [7:0]      reg_rdata_i,
    output awm_pkg::awm_reg_req_t reg_req_o
);
    // ------------------------------------------------------------
    // request driving
    // ------------------------------------------------------------
    // idle request at time zero so the block never sees unknowns
    initial reg_req_o = '0;

    // one-cycle write strobe; the data is written as given, with no check that it is a real time
    task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_req_o <= '{1'b1, a, d};
        @(posedge core_clk_i);
        reg_req_o.wr_en <= 1'b0;
    endtask

    // address held, data is registered one edge after it is taken
    task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        reg_req_o <= '{1'b0, a, 8'h00};
        @(posedge core_clk_i);
        @(negedge core_clk_i);
        d = reg_rdata_i;
    endtask
endmodule

/* File: testbench/awm_alarm_weekday_match_tb.sv */
// self-checking bench for the alarm weekday match block
`timescale 1ns/100ps
module awm_alarm_weekday_match_tb;
    logic                  core_clk;
    logic                  reset;
    awm_pkg::awm_reg_req_t reg_req;
    logic [7:0]            reg_rdata;
    awm_pkg::awm_time_t    cur_time;
    logic                  minute_tick;
    logic                  osc_halt;
    logic [1:0]            alarm_pulse;
    logic [1:0]            alarm_match;
    int                    num_errors = 0;
    int                    checked = 0;

    // ------------------------------------------------------------
    // instances and clock
    // ------------------------------------------------------------
    awm_alarm_weekday_match awm_alarm_weekday_match_inst (
        .core_clk_i      (core_clk),
        .reset_i         (reset),
        .reg_req_i       (reg_req),
        .reg_rdata_o     (reg_rdata),
        .cur_time_i      (cur_time),
        .minute_tick_i   (minute_tick),
        .osc_halt_flag_i (osc_halt),
        .alarm_pulse_o   (alarm_pulse),
        .alarm_match_o   (alarm_match)
    );
    awm_host_model host_inst (
        .core_clk_i  (core_clk),
        .reg_rdata_i (reg_rdata),
        .reg_req_o   (reg_req)
    );
    always #25 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host_inst.read_reg(a, d);
        chk(d, exp);
    endtask
    // minute update at 00 minutes; pulse must last exactly one cycle
    task automatic tick(input logic [2:0] w, input logic [5:0] h, input logic [1:0] exp);
        @(posedge core_clk);
        cur_time <= '{7'h00, h, w};
        minute_tick <= 1'b1;
        @(posedge core_clk);
        minute_tick <= 1'b0;
        @(negedge core_clk);
        chk({6'h00, alarm_pulse}, {6'h00, exp});
        chk({6'h00, alarm_match}, {6'h00, exp});
        @(negedge core_clk);
        chk({6'h00, alarm_pulse}, 8'h00);
    endtask
    task automatic results;
        $display("checked %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        reset = 1'b1;
        cur_time = '0;
        minute_tick = 1'b0;
        osc_halt = 1'b0;
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        rd(4'ha, 8'h00);
        host_inst.write_reg(4'ha, 8'hff);
        rd(4'ha, 8'h7f);
        host_inst.write_reg(4'hd, 8'hff);
        rd(4'hd, 8'h7f);
        host_inst.write_reg(4'h9, 8'hff);
        rd(4'h9, 8'h3f);
        host_inst.write_reg(4'h8, 8'hff);
        rd(4'h8, 8'h7f);
        rd(4'he, 8'h00);
        $display("test registers done");
        // channel b left with no days enabled so it must stay silent
        host_inst.write_reg(4'h8, 8'h00);
        host_inst.write_reg(4'h9, 8'h12);
        host_inst.write_reg(4'hc, 8'h12);
        rd(4'hc, 8'h12);
        host_inst.write_reg(4'hd, 8'h00);
        for (int d = 0; d < 7; d++)
        begin
            host_inst.write_reg(4'ha, 8'(1 << d));
            for (int w = 0; w < 8; w++)
                tick(3'(w), 6'h12, {1'b0, w == d});
        end
        tick(3'h6, 6'h32, 2'b00);
        host_inst.write_reg(4'hd, 8'h40);
        tick(3'h6, 6'h12, 2'b11);
        // match still held, but no new minute so no second pulse
        repeat (3) @(negedge core_clk) chk({6'h00, alarm_pulse}, 8'h00);
        $display("test weekday match done");
        @(posedge core_clk);
        osc_halt <= 1'b1;
        rd(4'ha, 8'h00);
        rd(4'h9, 8'h00);
        // a write while halted must be dropped
        host_inst.write_reg(4'ha, 8'h7f);
        rd(4'ha, 8'h00);
        tick(3'h6, 6'h12, 2'b00);
        @(posedge core_clk);
        osc_halt <= 1'b0;
        rd(4'hd, 8'h00);
        $display("test oscillator halt done");
        results();
    end
endmodule
